/* File: logic/pbsp_device.sv */
// How it works
// - Eighteen low address bits form transaction address
// - Burst flag low during burst, high single
// - Next-beat request asks for the following beats
// - Dropping next-beat request ends burst supply
// - Size 01 byte, 10 half, 00 word
// - Acknowledge low when data taken or given
// - Everything on rising edge of bus clock
// - Bus clock selectable for internal system bus
// - Internal bus error gives transfer-error low
// - Retry asks master to release and reissue
// - Data bus width 8, 16 or 32
// - Master drives writes, port drives reads only
// - One parity lane per data byte
// - Transfer strobe marks each transaction
// - Selected when low select low, high high
module pbsp_device #(
	parameter int   DATA_WIDTH = 32,
	parameter logic ODD_PARITY = 1'b1
) (
	// Clock and reset
	input  wire logic        core_clk,
	input  wire logic        rst,
	// Host bus pins
	pbsp_if.device           bus,
	// Clock source choice
	input  wire logic        hostClkSource,
	output logic             sysBusClkSel,
	// Internal system bus
	output logic             sysReq,
	output logic             sysWrite,
	output logic [17:0]      sysAddr,
	output logic [1:0]       sysSize,
	output logic [31:0]      sysWdata,
	input  wire logic        sysDone,
	input  wire logic        sysErr,
	input  wire logic        sysRetry,
	input  wire logic [31:0] sysRdata,
	// Status
	output logic             parityError
);

	// =========================================================
	// State
	typedef struct packed {
		pbsp_pkg::pbsp_dev_state_t state;
		logic [17:0] addr;
		logic [1:0]  size;
		logic        write;
		logic        burst;
		logic [1:0]  beat;
		logic [31:0] wdata;
		logic [31:0] rdata;
		logic [3:0]  rpar;
		logic        dataOe;
		logic        ackN;
		logic        errN;
		logic        rtryN;
		logic        req;
		logic        parErr;
		logic        clkSel;
	} pbsp_dev_t;

	localparam pbsp_dev_t DEV_RESET = '{
		state: pbsp_pkg::DEV_IDLE,
		addr: 18'h00000,
		size: pbsp_pkg::SIZE_WORD,
		write: 1'b0,
		burst: 1'b0,
		beat: 2'h0,
		wdata: 32'h00000000,
		rdata: 32'h00000000,
		rpar: 4'h0,
		dataOe: 1'b0,
		ackN: 1'b1,
		errN: 1'b1,
		rtryN: 1'b1,
		req: 1'b0,
		parErr: 1'b0,
		clkSel: 1'b0
	};

	// Narrow buses sit in the low lanes
	localparam logic [31:0] DMASK = pbsp_pkg::dataMask(DATA_WIDTH);
	localparam logic [3:0] PMASK = pbsp_pkg::laneMask(DATA_WIDTH);
	localparam logic [17:0] STEP = 18'(DATA_WIDTH / 8);

	pbsp_dev_t s;
	pbsp_dev_t next_s;
	logic      selected;
	logic      laneBad;
	logic      wantErr;
	logic      wantRetry;
	logic      wantAck;
	logic      burstGoes;

	assign selected = !bus.selectLowN && bus.selectHigh;
	assign laneBad = ((pbsp_pkg::lanePar(bus.dataBus, ODD_PARITY) ^ bus.parityLanes)
		& PMASK) != 4'h0;

	// Error outranks retry, retry outranks ack
	assign wantErr = sysErr;
	assign wantRetry = sysRetry && !sysErr;
	assign wantAck = !sysErr && !sysRetry;
	assign burstGoes = !s.ackN && s.burst && !bus.burstN && bus.nextBeat
		&& s.beat != pbsp_pkg::BEAT_LAST;

	// =========================================================
	// Next state
	always_comb
	begin
		next_s = s;
		next_s.ackN = 1'b1;
		next_s.errN = 1'b1;
		next_s.rtryN = 1'b1;
		next_s.dataOe = 1'b0;
		next_s.parErr = 1'b0;
		next_s.clkSel = hostClkSource;
		case (s.state)
			pbsp_pkg::DEV_IDLE:
			begin
				// Only a strobe with both selects valid opens a transfer
				if (!bus.transferStrobeN && selected)
				begin
					next_s.addr = bus.addr;
					next_s.size = bus.transferSize;
					next_s.write = !bus.readNotWrite;
					next_s.burst = !bus.burstN;
					next_s.beat = 2'h0;
					next_s.wdata = bus.dataBus & DMASK;
					next_s.parErr = !bus.readNotWrite && laneBad;
					next_s.req = 1'b1;
					next_s.state = pbsp_pkg::DEV_ACCESS;
				end
			end
			pbsp_pkg::DEV_ACCESS:
			begin
				if (sysDone)
				begin
					next_s.req = 1'b0;
					next_s.rdata = sysRdata & DMASK;
					next_s.rpar = pbsp_pkg::lanePar(sysRdata, ODD_PARITY) & PMASK;
					// Error outranks retry so only one terminator fires
					next_s.errN = !wantErr;
					next_s.rtryN = !wantRetry;
					next_s.ackN = !wantAck;
					next_s.dataOe = !s.write && wantAck;
					next_s.state = pbsp_pkg::DEV_TERM;
				end
			end
			pbsp_pkg::DEV_TERM:
			begin
				// Burst goes on only after a clean beat that the master still wants
				if (burstGoes)
				begin
					next_s.beat = s.beat + 2'h1;
					next_s.addr = s.addr + STEP;
					next_s.state = pbsp_pkg::DEV_NEXT;
				end
				else
				begin
					next_s.burst = 1'b0;
					next_s.state = pbsp_pkg::DEV_IDLE;
				end
			end
			pbsp_pkg::DEV_NEXT:
			begin
				// Master moves its data on the acknowledge edge
				next_s.wdata = bus.dataBus & DMASK;
				next_s.parErr = s.write && laneBad;
				next_s.req = 1'b1;
				next_s.state = pbsp_pkg::DEV_ACCESS;
			end
			default:
			begin
				next_s = DEV_RESET;
			end
		endcase
	end

	// =========================================================
	// Registers
	always_ff @(posedge core_clk)
	begin
		if (rst)
			s <= DEV_RESET;
		else
			s <= next_s;
	end

	// =========================================================
	// Outputs
	assign bus.transferAckN = s.ackN;
	assign bus.transferErrorN = s.errN;
	assign bus.retryRequestN = s.rtryN;
	assign bus.devData = s.rdata;
	assign bus.devPar = s.rpar;
	assign bus.devDataOe = s.dataOe;
	assign sysBusClkSel = s.clkSel;
	assign sysReq = s.req;
	assign sysWrite = s.write;
	assign sysAddr = s.addr;
	assign sysSize = s.size;
	assign sysWdata = s.wdata;
	assign parityError = s.parErr;

endmodule // pbsp_device

/* File: logic/pbsp_host.sv */
module pbsp_host #(
	parameter int   DATA_WIDTH = 32,
	parameter logic ODD_PARITY = 1'b1
) (
	// Clock and reset
	input  wire logic        core_clk,
	input  wire logic        rst,
	// Host bus pins
	pbsp_if.host             bus,
	// Requests
	input  wire logic        reqValid,
	output logic             reqReady,
	input  wire logic        reqWrite,
	input  wire logic [31:0] reqAddr,
	input  wire logic [1:0]  reqSize,
	input  wire logic        reqBurst,
	input  wire logic        abortBurst,
	input  wire logic [31:0] beatWdata,
	// Replies
	output logic             respValid,
	output logic [1:0]       respStatus,
	output logic [31:0]      respData,
	output logic             respParityOk,
	output logic             respLast
);

	// =========================================================
	// State
	typedef struct packed {
		pbsp_pkg::pbsp_host_state_t state;
		logic [17:0] addr;
		logic [1:0]  size;
		logic        write;
		logic        burst;
		logic        next;
		logic [1:0]  beat;
		logic [31:0] data;
		logic        dataOe;
		logic        strobeN;
		logic        sel;
		logic [3:0]  gap;
		logic        rValid;
		logic [1:0]  rStatus;
		logic [31:0] rData;
		logic        rParOk;
		logic        rLast;
	} pbsp_host_t;

	localparam pbsp_host_t HOST_RESET = '{
		state: pbsp_pkg::HOST_IDLE,
		addr: 18'h00000,
		size: pbsp_pkg::SIZE_WORD,
		write: 1'b0,
		burst: 1'b0,
		next: 1'b0,
		beat: 2'h0,
		data: 32'h00000000,
		dataOe: 1'b0,
		strobeN: 1'b1,
		sel: 1'b0,
		gap: 4'h0,
		rValid: 1'b0,
		rStatus: pbsp_pkg::STAT_OK,
		rData: 32'h00000000,
		rParOk: 1'b0,
		rLast: 1'b0
	};

	localparam logic [3:0] PMASK = pbsp_pkg::laneMask(DATA_WIDTH);
	localparam logic [17:0] STEP = 18'(DATA_WIDTH / 8);

	pbsp_host_t s;
	pbsp_host_t next_s;

	// =========================================================
	// Next state
	always_comb
	begin
		next_s = s;
		next_s.rValid = 1'b0;
		next_s.rLast = 1'b0;
		if (abortBurst)
			next_s.next = 1'b0;
		case (s.state)
			pbsp_pkg::HOST_IDLE:
			begin
				if (reqValid)
				begin
					next_s.addr = reqAddr[17:0];
					next_s.size = reqSize;
					next_s.write = reqWrite;
					next_s.burst = reqBurst;
					next_s.next = reqBurst && !abortBurst;
					next_s.beat = 2'h0;
					next_s.data = beatWdata;
					next_s.dataOe = reqWrite;
					next_s.strobeN = 1'b0;
					next_s.sel = 1'b1;
					next_s.state = pbsp_pkg::HOST_STROBE;
				end
			end
			pbsp_pkg::HOST_STROBE:
			begin
				next_s.strobeN = 1'b1;
				next_s.state = pbsp_pkg::HOST_WAIT;
			end
			pbsp_pkg::HOST_WAIT:
			begin
				if (!bus.transferAckN)
				begin
					next_s.rValid = 1'b1;
					next_s.rStatus = pbsp_pkg::STAT_OK;
					next_s.rData = bus.dataBus;
					next_s.rParOk = ((pbsp_pkg::lanePar(bus.dataBus, ODD_PARITY)
						^ bus.parityLanes) & PMASK) == 4'h0;
					if (s.burst && s.next && s.beat != pbsp_pkg::BEAT_LAST)
					begin
						next_s.beat = s.beat + 2'h1;
						next_s.addr = s.addr + STEP;
						next_s.data = beatWdata;
						next_s.next = !abortBurst && (s.beat + 2'h1) != pbsp_pkg::BEAT_LAST;
					end
					else
					begin
						next_s = HOST_RESET;
						next_s.rValid = 1'b1;
						next_s.rStatus = pbsp_pkg::STAT_OK;
						next_s.rData = bus.dataBus;
						next_s.rParOk = ((pbsp_pkg::lanePar(bus.dataBus, ODD_PARITY)
							^ bus.parityLanes) & PMASK) == 4'h0;
						next_s.rLast = 1'b1;
					end
				end
				else if (!bus.transferErrorN)
				begin
					next_s = HOST_RESET;
					next_s.rValid = 1'b1;
					next_s.rStatus = pbsp_pkg::STAT_ERR;
					next_s.rLast = 1'b1;
				end
				else if (!bus.retryRequestN)
				begin
					// Let go of the bus, then reissue the same beat
					next_s.dataOe = 1'b0;
					next_s.sel = 1'b0;
					next_s.gap = pbsp_pkg::RETRY_GAP;
					next_s.state = pbsp_pkg::HOST_BACKOFF;
				end
			end
			pbsp_pkg::HOST_BACKOFF:
			begin
				if (s.gap == 4'h0)
				begin
					next_s.dataOe = s.write;
					next_s.strobeN = 1'b0;
					next_s.sel = 1'b1;
					next_s.state = pbsp_pkg::HOST_STROBE;
				end
				else
					next_s.gap = s.gap - 4'h1;
			end
			default:
			begin
				next_s = HOST_RESET;
			end
		endcase
	end

	// =========================================================
	// Registers
	always_ff @(posedge core_clk)
	begin
		if (rst)
			s <= HOST_RESET;
		else
			s <= next_s;
	end

	// =========================================================
	// Outputs
	assign reqReady = (s.state == pbsp_pkg::HOST_IDLE);
	assign bus.addr = s.addr;
	assign bus.burstN = !s.burst;
	assign bus.nextBeat = s.next;
	assign bus.transferSize = s.size;
	assign bus.transferStrobeN = s.strobeN;
	assign bus.readNotWrite = !s.write;
	assign bus.selectLowN = !s.sel;
	assign bus.selectHigh = s.sel;
	assign bus.hostData = s.data;
	assign bus.hostPar = pbsp_pkg::lanePar(s.data, ODD_PARITY) & PMASK;
	assign bus.hostDataOe = s.dataOe;
	assign respValid = s.rValid;
	assign respStatus = s.rStatus;
	assign respData = s.rData;
	assign respParityOk = s.rParOk;
	assign respLast = s.rLast;

endmodule // pbsp_host

/* File: logic/pbsp_if.sv */
interface pbsp_if;

	// =========================================================
	// Master to port
	logic [17:0] addr;
	logic        burstN;
	logic        nextBeat;
	logic [1:0]  transferSize;
	logic        transferStrobeN;
	logic        readNotWrite;
	logic        selectLowN;
	logic        selectHigh;
	logic [31:0] hostData;
	logic [3:0]  hostPar;
	logic        hostDataOe;

	// =========================================================
	// Port to master
	logic        transferAckN;
	logic        transferErrorN;
	logic        retryRequestN;
	logic [31:0] devData;
	logic [3:0]  devPar;
	logic        devDataOe;

	// =========================================================
	// Shared data wires, pulled up when nobody drives
	logic [31:0] dataBus;
	logic [3:0]  parityLanes;

	assign dataBus = devDataOe ? devData : hostDataOe ? hostData : pbsp_pkg::BUS_IDLE;
	assign parityLanes = devDataOe ? devPar : hostDataOe ? hostPar : pbsp_pkg::PAR_IDLE;

	modport device (
		input  addr, burstN, nextBeat, transferSize, transferStrobeN, readNotWrite,
		input  selectLowN, selectHigh, dataBus, parityLanes,
		output transferAckN, transferErrorN, retryRequestN, devData, devPar, devDataOe
	);

	modport host (
		output addr, burstN, nextBeat, transferSize, transferStrobeN, readNotWrite,
		output selectLowN, selectHigh, hostData, hostPar, hostDataOe,
		input  transferAckN, transferErrorN, retryRequestN, dataBus, parityLanes
	);

endinterface

/* File: logic/pbsp_pkg.sv */
package pbsp_pkg;

	// =========================================================
	// Pin widths and encodings
	localparam int ADDR_W = 18;
	localparam int BUS_W = 32;
	localparam int LANES = 4;
	localparam logic [1:0] SIZE_WORD = 2'h0;
	localparam logic [1:0] SIZE_BYTE = 2'h1;
	localparam logic [1:0] SIZE_HALF = 2'h2;
	localparam logic [1:0] BEAT_LAST = 2'h3;
	localparam logic [31:0] BUS_IDLE = 32'hFFFFFFFF;
	localparam logic [3:0] PAR_IDLE = 4'hF;

	// =========================================================
	// Host reply status
	localparam logic [1:0] STAT_OK = 2'h0;
	localparam logic [1:0] STAT_ERR = 2'h1;

	// =========================================================
	// Host retry backoff, in bus clocks
	localparam logic [3:0] RETRY_GAP = 4'h4;

	// =========================================================
	// State encodings
	typedef enum logic [1:0] {DEV_IDLE, DEV_ACCESS, DEV_TERM, DEV_NEXT} pbsp_dev_state_t;
	typedef enum logic [1:0] {HOST_IDLE, HOST_STROBE, HOST_WAIT, HOST_BACKOFF} pbsp_host_state_t;

	// =========================================================
	// Lane helpers
	function automatic logic [3:0] laneMask(input int width);
		laneMask = (width == 8) ? 4'h1 : (width == 16) ? 4'h3 : 4'hF;
	endfunction

	function automatic logic [31:0] dataMask(input int width);
		dataMask = (width == 8) ? 32'h000000FF : (width == 16) ? 32'h0000FFFF : 32'hFFFFFFFF;
	endfunction

	// Lane 0 is bits 7:0 up to lane 3 on bits 31:24
	function automatic logic [3:0] lanePar(input logic [31:0] d, input logic odd);
		logic [3:0] p;
		p = 4'h0;
		for (int i = 0; i < LANES; i++)
			p[i] = (^d[i*8 +: 8]) ^ odd;
		lanePar = p;
	endfunction

endpackage

/* File: sim/pbsp_monitor.sv */
module pbsp_monitor (
	// Clock and reset
	input wire logic        core_clk,
	input wire logic        rst,
	// Master side
	input wire logic        transferStrobeN,
	input wire logic        selectLowN,
	input wire logic        selectHigh,
	input wire logic        readNotWrite,
	input wire logic        hostDataOe,
	// Port side
	input wire logic        transferAckN,
	input wire logic        transferErrorN,
	input wire logic        retryRequestN,
	input wire logic [31:0] devData,
	input wire logic [3:0]  devPar,
	input wire logic        devDataOe
);
	timeunit 1ns;
	timeprecision 1ps;

	// ========================
	// Shared timing
	default clocking cb @(posedge core_clk);
	endclocking
	default disable iff (rst);

	sequence take;
		!transferStrobeN && !selectLowN && selectHigh;
	endsequence

	sequence term;
		!transferAckN || !transferErrorN || !retryRequestN;
	endsequence

	// ========================
	// Checks
	one_term_a: assert property ($onehot0({!transferAckN, !transferErrorN, !retryRequestN}))
		else $error("two terminators at once");
	term_pulse_a: assert property (term |=> transferAckN && transferErrorN && retryRequestN)
		else $error("terminator held too long");
	no_early_a: assert property (take |=> not term)
		else $error("terminator in the cycle after strobe");
	term_bound_a: assert property (take |-> ##[2:40] term)
		else $error("strobe never terminated");
	read_oe_a: assert property (!transferAckN |-> devDataOe == readNotWrite)
		else $error("data drive does not match direction at ack");
	oe_ack_a: assert property (devDataOe |-> !transferAckN && !hostDataOe)
		else $error("port drives data outside read ack");
	par_out_a: assert property (devDataOe |-> devPar ==
		{~^devData[31:24], ~^devData[23:16], ~^devData[15:8], ~^devData[7:0]})
		else $error("read parity lanes wrong");
	strobe_sel_a: assert property (!transferStrobeN |-> !selectLowN && selectHigh ##1 transferStrobeN)
		else $error("strobe without select or too long");
	retry_gap_a: assert property (!retryRequestN |=> transferStrobeN [*4] ##[1:8] take)
		else $error("retried cycle not reissued after backoff");
endmodule // pbsp_monitor

/* File: sim/tb_top.sv */
module tb_top;
	timeunit 1ns;
	timeprecision 1ps;

	// ========================
	// Stimulus and outputs
	logic        core_clk, rst, hostClkSource, sysDone, sysErr, sysRetry;
	logic        reqValid, reqWrite, reqBurst, abortBurst;
	logic [31:0] sysRdata, reqAddr, beatWdata, sysWdata, respData;
	logic [1:0]  reqSize, sysSize, respStatus;
	logic [17:0] sysAddr;
	logic        sysBusClkSel, sysReq, sysWrite, parityError;
	logic        reqReady, respValid, respParityOk, respLast;
	// Mode, write, size, address, data
	logic [54:0] sysQ[$];
	// Data check, last, status, data
	logic [35:0] expQ[$];
	logic [35:0] e;
	int          err_total = 0;
	int          checks_done = 0;

	// ========================
	// Both ends and the checker
	pbsp_if busIf ();
	pbsp_device i_pbsp_device (.core_clk, .rst, .bus(busIf), .hostClkSource, .sysBusClkSel,
		.sysReq, .sysWrite, .sysAddr, .sysSize, .sysWdata, .sysDone, .sysErr, .sysRetry,
		.sysRdata, .parityError);
	pbsp_host i_pbsp_host (.core_clk, .rst, .bus(busIf), .reqValid, .reqReady, .reqWrite,
		.reqAddr, .reqSize, .reqBurst, .abortBurst, .beatWdata, .respValid, .respStatus,
		.respData, .respParityOk, .respLast);
	pbsp_monitor u_mon (.core_clk, .rst, .transferStrobeN(busIf.transferStrobeN),
		.selectLowN(busIf.selectLowN), .selectHigh(busIf.selectHigh),
		.readNotWrite(busIf.readNotWrite), .hostDataOe(busIf.hostDataOe),
		.transferAckN(busIf.transferAckN), .transferErrorN(busIf.transferErrorN),
		.retryRequestN(busIf.retryRequestN), .devData(busIf.devData),
		.devPar(busIf.devPar), .devDataOe(busIf.devDataOe));

	// ========================
	// Helpers
	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		checks_done++;
		if (seen !== exp)
		begin
			err_total++;
			$display("MISMATCH %0t seen %h expected %h", $time, seen, exp);
		end
	endtask

	task automatic final_report;
		$display("checks %0d errors %0d", checks_done, err_total);
		if (err_total == 0 && checks_done > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask

	// Mode 1 is a system bus error, mode 2 one retry first
	task automatic req(input logic w, input logic [1:0] sz, input logic [1:0] md,
		input int beats, input logic ab);
		logic [31:0] a;
		logic [31:0] d;
		logic [31:0] dv[4];
		a = $urandom & 32'hFFFFFFF0;
		for (int k = 0; k < beats; k++)
		begin
			d = $urandom;
			dv[k] = d;
			sysQ.push_back({md, w, sz, a[17:0] + 18'(4 * k), d});
			expQ.push_back({!w && md != 2'h1, k == beats - 1,
				md == 2'h1 ? pbsp_pkg::STAT_ERR : pbsp_pkg::STAT_OK, d});
		end
		@(negedge core_clk);
		while (reqReady !== 1'h1)
			@(negedge core_clk);
		@(posedge core_clk);
		reqValid <= 1'h1;
		reqWrite <= w;
		reqAddr <= a;
		reqSize <= sz;
		reqBurst <= beats > 1 || ab;
		abortBurst <= ab;
		beatWdata <= dv[0];
		@(posedge core_clk);
		reqValid <= 1'h0;
		// Next beat data must stand before the ack edge that takes it
		for (int k = 1; k < beats; k++)
		begin
			beatWdata <= dv[k];
			@(negedge core_clk);
			while (respValid !== 1'h1)
				@(negedge core_clk);
			@(posedge core_clk);
		end
	endtask

	// ========================
	// Clock and watchdog
	initial
	begin
		core_clk = 1'h0;
		forever #25 core_clk = ~core_clk;
	end

	initial
	begin
		repeat (4000) @(posedge core_clk);
		err_total++;
		final_report();
	end

	// ========================
	// Internal system bus responder
	initial
	begin
		logic [54:0] s;
		forever
		begin
			@(negedge core_clk);
			if (sysReq === 1'h1)
			begin
				s = sysQ.pop_front();
				chk(32'(sysAddr), 32'(s[49:32]));
				chk(32'(sysSize), 32'(s[51:50]));
				chk(32'(sysWrite), 32'(s[52]));
				if (s[52])
					chk(sysWdata, s[31:0]);
				repeat ($urandom % 3) @(posedge core_clk);
				@(posedge core_clk);
				sysDone <= 1'h1;
				sysErr <= s[54:53] == 2'h1;
				sysRetry <= s[54:53] == 2'h2;
				sysRdata <= s[31:0];
				@(posedge core_clk);
				sysDone <= 1'h0;
				sysErr <= 1'h0;
				sysRetry <= 1'h0;
				sysRdata <= $urandom;
				if (s[54:53] == 2'h2)
					sysQ.push_front({2'h0, s[52:0]});
				@(posedge core_clk);
			end
		end
	end

	// ========================
	// Reply watcher
	always @(negedge core_clk)
	begin
		if (respValid === 1'h1)
		begin
			e = expQ.pop_front();
			chk(32'(respStatus), 32'(e[33:32]));
			chk(32'(respLast), 32'(e[34]));
			if (e[35])
				chk(respData, e[31:0]);
			if (e[35])
				chk(32'(respParityOk), 32'h1);
		end
		if (parityError !== 1'h0)
			chk(32'(parityError), 32'h0);
	end

	// ========================
	// Main sequence
	initial
	begin
		logic [1:0] sz[3];
		sz = '{pbsp_pkg::SIZE_WORD, pbsp_pkg::SIZE_BYTE, pbsp_pkg::SIZE_HALF};
		rst = 1'h1;
		{hostClkSource, sysDone, sysErr, sysRetry, reqValid, reqWrite, reqBurst} = 7'h0;
		{abortBurst, sysRdata, reqAddr, beatWdata, reqSize} = 99'h0;
		void'($urandom(14));
		repeat (2) @(posedge core_clk);
		rst <= 1'h0;
		hostClkSource <= 1'h1;
		repeat (2) @(posedge core_clk);
		@(negedge core_clk);
		chk(32'(sysBusClkSel), 32'h1);
		for (int i = 0; i < 3; i++)
		begin
			req(1'h1, sz[i], 2'h0, 1, 1'h0);
			req(1'h0, sz[i], 2'h0, 1, 1'h0);
		end
		req(1'h1, sz[0], 2'h1, 1, 1'h0);
		req(1'h0, sz[0], 2'h1, 1, 1'h0);
		req(1'h1, sz[1], 2'h2, 1, 1'h0);
		req(1'h0, sz[0], 2'h2, 1, 1'h0);
		req(1'h0, sz[0], 2'h0, 4, 1'h0);
		req(1'h1, sz[0], 2'h0, 4, 1'h0);
		req(1'h0, sz[0], 2'h0, 1, 1'h1);
		for (int i = 0; i < 8; i++)
			req(1'($urandom), sz[$urandom % 3], 2'h0, 1, 1'h0);
		hostClkSource <= 1'h0;
		repeat (40) @(posedge core_clk);
		@(negedge core_clk);
		chk(32'(sysBusClkSel), 32'h0);
		chk(32'(expQ.size() + sysQ.size()), 32'h0);
		final_report();
	end
endmodule // tb_top
